// ===== design/cis_pkg.sv
// package: register map, field layout and bus types for the channel interrupt summary
package cis_pkg;
  localparam int CIS_NUM_CHAN = 17;
  localparam int CIS_ADDR_W = 12;
  localparam logic [11:0] CIS_SUMMARY_LOW_OFS = 12'h2c0;
  localparam logic [11:0] CIS_SUMMARY_HIGH_OFS = 12'h300;
  localparam logic [11:0] CIS_SUMMARY_ZERO_OFS = 12'h380;
  localparam logic [11:0] CIS_SRC_ENABLE_LOW_OFS = 12'h400;
  localparam logic [11:0] CIS_SRC_ENABLE_HIGH_OFS = 12'h404;
  localparam logic [11:0] CIS_SRC_ENABLE_ZERO_OFS = 12'h408;
  localparam int CIS_CHAN_ZERO_BIT = 7;
  localparam int CIS_GROUP_W = 8;
  localparam logic [7:0] CIS_SUMMARY_RST = 8'h00;
  localparam logic [7:0] CIS_ENABLE_RST = 8'hff;
  localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;

  // read answer carried as one unit
  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } cis_rd_s;
endpackage

// ===== design/cis_or_reduce.sv
// per-channel reduction of enabled interrupt status flags
`timescale 1ns/1ps
module cis_or_reduce #(
  parameter int CHANS = 17,
  parameter int SRCS = 8
) (
  input wire logic [CHANS*SRCS-1:0] status,
  input wire logic [CHANS-1:0] enable,
  output logic [CHANS-1:0] pending
);
  // a disabled channel reports nothing even with flags set
  always_comb begin
    for (int c = 0; c < CHANS; c++) begin
      pending[c] = enable[c] & (|status[c*SRCS +: SRCS]);
    end
  end
endmodule

// ===== design/cis_top.sv
// channel interrupt summary registers behind an axi4-lite slave
// Contract
// - channels 8..1 appear at the first group offset, bit 7 for channel 8 down to bit 0 for channel 1.
// - channels 16..9 appear at the second group offset, bit 7 for channel 16 down to bit 0 for channel 9.
// - a summary bit reads one while its channel is enabled and any interrupt source of that channel is asserted.
// - a summary bit reads zero when its channel has nothing pending, and after reset.
// - channel 0 appears in bit 7 of a third summary register, other bits reserved and zero.
`timescale 1ns/1ps
module cis_top
  import cis_pkg::*;
#(
  parameter int SRCS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CIS_NUM_CHAN*SRCS-1:0] chan_irq_status,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [CIS_NUM_CHAN-1:0] pending;
  logic [CIS_NUM_CHAN-1:0] enable_q, enable_d;
  logic [CIS_NUM_CHAN-1:0] summary_q, summary_d;
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  cis_rd_s rd_q, rd_d;
  logic do_write;

  // word-aligned register decode, shared by read and write sides
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    logic [2:0] s;
    s = 3'h0;
    unique case ({a[11:2], 2'h0})
      CIS_SUMMARY_LOW_OFS: s = 3'h1;
      CIS_SUMMARY_HIGH_OFS: s = 3'h2;
      CIS_SUMMARY_ZERO_OFS: s = 3'h3;
      CIS_SRC_ENABLE_LOW_OFS: s = 3'h4;
      CIS_SRC_ENABLE_HIGH_OFS: s = 3'h5;
      CIS_SRC_ENABLE_ZERO_OFS: s = 3'h6;
      default: s = 3'h0;
    endcase
    return s;
  endfunction

  // byte lane 0 merge; registers are eight bits wide
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] st);
    return st[0] ? d[7:0] : old;
  endfunction

  // any source flag set per channel, used by the summary checks
  function automatic logic [CIS_NUM_CHAN-1:0] chan_any(input logic [CIS_NUM_CHAN*SRCS-1:0] st);
    logic [CIS_NUM_CHAN-1:0] a;
    a = '0;
    for (int c = 0; c < CIS_NUM_CHAN; c++) begin
      a[c] = |st[c*SRCS +: SRCS];
    end
    return a;
  endfunction

  cis_or_reduce #(
    .CHANS(CIS_NUM_CHAN),
    .SRCS(SRCS)
  ) u_reduce (
    .status(chan_irq_status),
    .enable(enable_q),
    .pending(pending)
  );

  // summary is registered once so outputs come from flops; one cycle lag
  always_comb begin
    summary_d = pending;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      summary_q <= '0;
    end else begin
      summary_q <= summary_d;
    end
  end

  // an enabled channel with any flag set shows one a cycle later
  property p_pending_sets;
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> ($past(chan_any(chan_irq_status) & enable_q) & ~summary_q) == '0;
  endproperty
  a_pending_sets: assert property (p_pending_sets)
    else $error("summary bit low while its channel has a flag set");

  // a quiet or disabled channel shows zero a cycle later
  property p_idle_clears;
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> (summary_q & ~$past(chan_any(chan_irq_status) & enable_q)) == '0;
  endproperty
  a_idle_clears: assert property (p_idle_clears)
    else $error("summary bit high while its channel is quiet");

  // reset clears the summary and any pending answer
  property p_reset_clear;
    @(posedge aclk)
    !aresetn |=> summary_q == '0 && !s_axi_rvalid && !s_axi_bvalid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("summary not clear after reset");

  // write channel: address and data accepted in either order, then one response
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    enable_d = enable_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = CIS_RESP_OKAY;
      unique case (reg_sel(awaddr_q))
        3'h1, 3'h2, 3'h3: bresp_d = CIS_RESP_OKAY; // summary ignores writes
        3'h4: enable_d[8:1] = lane0(enable_q[8:1], wdata_q, wstrb_q);
        3'h5: enable_d[16:9] = lane0(enable_q[16:9], wdata_q, wstrb_q);
        3'h6: enable_d[0] = wstrb_q[0] ? wdata_q[CIS_CHAN_ZERO_BIT] : enable_q[0];
        default: bresp_d = CIS_RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= CIS_RESP_OKAY;
      enable_q <= '1;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      enable_q <= enable_d;
    end
  end

  // a write to a summary register leaves every control unchanged
  property p_summary_write_ignored;
    @(posedge aclk) disable iff (!aresetn)
    do_write && (reg_sel(awaddr_q) inside {3'h1, 3'h2, 3'h3}) |=> enable_q == $past(enable_q) && s_axi_bresp == CIS_RESP_OKAY;
  endproperty
  a_summary_write_ignored: assert property (p_summary_write_ignored)
    else $error("write to a summary register had an effect");

  // the write response stands until the master takes it
  property p_write_hold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("write response dropped before it was taken");

  // no new write is taken while a response is outstanding
  property p_aw_blocked;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_blocked: assert property (p_aw_blocked)
    else $error("write ready high while a response is pending");

  // both halves held give a response on the next cycle
  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing after address and data");

  // read channel: answer registered one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rd_d = rd_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rd_d.data = '0;
      rd_d.resp = CIS_RESP_OKAY;
      unique case (reg_sel(s_axi_araddr[11:0]))
        3'h1: rd_d.data[7:0] = summary_q[8:1];
        3'h2: rd_d.data[7:0] = summary_q[16:9];
        3'h3: rd_d.data[CIS_CHAN_ZERO_BIT] = summary_q[0];
        3'h4: rd_d.data[7:0] = enable_q[8:1];
        3'h5: rd_d.data[7:0] = enable_q[16:9];
        3'h6: rd_d.data[CIS_CHAN_ZERO_BIT] = enable_q[0];
        default: rd_d.resp = CIS_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rvalid_q <= rvalid_d;
      rd_q <= rd_d;
    end
  end

  // first group: channel 8 in bit 7 down to channel 1 in bit 0
  property p_summary_low;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr[11:0]) == 3'h1 |=> s_axi_rdata == {24'h0, $past(summary_q[8:1])};
  endproperty
  a_summary_low: assert property (p_summary_low)
    else $error("first group read does not match channels 8 to 1");

  // second group: channel 16 in bit 7 down to channel 9 in bit 0
  property p_summary_high;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr[11:0]) == 3'h2 |=> s_axi_rdata == {24'h0, $past(summary_q[16:9])};
  endproperty
  a_summary_high: assert property (p_summary_high)
    else $error("second group read does not match channels 16 to 9");

  // channel 0 alone in its bit, reserved bits zero
  property p_summary_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr[11:0]) == 3'h3 |=> s_axi_rdata == (32'($past(summary_q[0])) << CIS_CHAN_ZERO_BIT);
  endproperty
  a_summary_zero: assert property (p_summary_zero)
    else $error("channel zero read does not match its summary");

  // read data stands until the master takes it
  property p_read_hold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read answer changed before it was taken");

  // one read at a time
  property p_ar_blocked;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_blocked: assert property (p_ar_blocked)
    else $error("read address ready while an answer is pending");

  // unmapped reads answer with an error code
  property p_unmapped_read;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr[11:0]) == 3'h0 |=> s_axi_rresp == CIS_RESP_SLVERR;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not answered with an error");

  // an accepted address is answered on the next cycle
  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer missing after address accepted");

  // ready registered ahead from the next hold state, so capture needs valid and ready together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready <= !w_held_d && !bvalid_d;
      s_axi_arready <= !rvalid_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rd_q.data;
  assign s_axi_rresp = rd_q.resp;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the channel interrupt summary registers
`timescale 1ns/1ps
module testbench;
  import cis_pkg::*;
  localparam int S = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [CIS_NUM_CHAN*S-1:0] st = '0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int n_errors = 0;
  int check_count = 0;
  logic [CIS_NUM_CHAN-1:0] en = '1;
  logic [11:0] ofs [3] = '{CIS_SUMMARY_LOW_OFS, CIS_SUMMARY_HIGH_OFS, CIS_SUMMARY_ZERO_OFS};

  cis_top #(.SRCS(S)) u_cis_top (.aclk(aclk), .aresetn(aresetn), .chan_irq_status(st),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // 100 mhz clock
  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // bounded wait: a hung handshake ends the run
  task automatic hs(ref logic s);
    int k = 0;
    do begin @(posedge aclk); k++; end while (s !== 1'b1 && k < 50);
    if (s !== 1'b1) begin
      chk("handshake", 32'h1, 32'(s));
      stop_test;
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= 32'(a); arvalid <= 1'b1; rready <= 1'b1;
    hs(arready);
    arvalid <= 1'b0;
    hs(rvalid);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask

  // address and data may be taken in either order
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
    bit ad = 0, wd = 0;
    @(posedge aclk);
    awaddr <= 32'(a); wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int k = 0; !(ad && wd); k++) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
      if (k == 50) begin chk("write accept", 32'h1, 32'h0); stop_test; end
    end
    hs(bvalid);
    chk("bresp", 32'(e), 32'(bresp));
    bready <= 1'b0;
  endtask

  // reference model: or of each channel's flags, gated by its enable, placed per register
  function automatic logic [31:0] exp_reg(input int i);
    logic [31:0] e = '0;
    for (int c = 0; c < 8; c++) e[c] = (i == 0) ? en[c+1] & |st[(c+1)*S +: S] : en[c+9] & |st[(c+9)*S +: S];
    return (i == 2) ? 32'(en[0] & |st[0 +: S]) << CIS_CHAN_ZERO_BIT : e;
  endfunction

  task automatic chk_all;
    logic [31:0] d; logic [1:0] r;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], d, r);
      chk("summary", exp_reg(i), d);
      chk("rresp", 32'(CIS_RESP_OKAY), 32'(r));
    end
  endtask

  // main sequence
  initial begin
    logic [31:0] d; logic [1:0] r;
    void'($urandom(8));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all;
    $display("test reset values done");
    for (int c = 0; c < CIS_NUM_CHAN; c++) begin
      @(posedge aclk);
      st <= '0;
      st[c*S + c%S] <= 1'b1;
      chk_all;
    end
    $display("test walking channel done");
    for (int n = 0; n < 24; n++) begin
      @(posedge aclk);
      st <= (n % 4 == 3) ? '0 : (CIS_NUM_CHAN*S)'({$urandom, $urandom});
      chk_all;
    end
    $display("test random status done");
    st <= (CIS_NUM_CHAN*S)'({$urandom, $urandom});
    for (int i = 0; i < 3; i++) wr(ofs[i], 32'h0000_00ff, CIS_RESP_OKAY);
    chk_all;
    $display("test summary write done");
    st <= '1;
    wr(CIS_SRC_ENABLE_LOW_OFS, 32'h0000_005a, CIS_RESP_OKAY);
    wr(CIS_SRC_ENABLE_HIGH_OFS, 32'h0000_00c3, CIS_RESP_OKAY);
    wr(CIS_SRC_ENABLE_ZERO_OFS, 32'h0000_0000, CIS_RESP_OKAY);
    en = {8'hc3, 8'h5a, 1'b0};
    chk_all;
    wr(CIS_SRC_ENABLE_LOW_OFS, 32'h0000_00ff, CIS_RESP_OKAY);
    wr(CIS_SRC_ENABLE_HIGH_OFS, 32'h0000_00ff, CIS_RESP_OKAY);
    wr(CIS_SRC_ENABLE_ZERO_OFS, 32'h0000_0080, CIS_RESP_OKAY);
    en = '1;
    chk_all;
    $display("test source enable done");
    rd(12'h010, d, r);
    chk("unmapped rresp", 32'(CIS_RESP_SLVERR), 32'(r));
    wr(12'h010, 32'h0000_0000, CIS_RESP_SLVERR);
    $display("test unmapped access done");
    stop_test;
  end
endmodule
